/* bench/pldld_div_model.sv */
// divider output model of one loop: reference and feedback pulses
// assumes the bench changes skew at will; it takes effect at period start
`timescale 1ns/1ns
module pldld_div_model #(
  parameter int PERIOD = 40,
  parameter int HIGH = 4
) (
  // clock
  input wire logic clk_i,
  // pair shape
  input wire logic en_i,
  input wire logic [7:0] skew_i,
  // divider outputs
  output logic ref_o,
  output logic fb_o
);
  int cnt_q;
  int skew_q;

  ////////////////////////////////////////////////////////////////////////
  // skew latched once a period so that a pair is never split by a change
  always @(posedge clk_i) begin
    if (!en_i) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    end
    if (cnt_q == 0) begin
      skew_q <= int'(skew_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // a stopped divider rests low
  assign ref_o = en_i && (cnt_q < HIGH);
  assign fb_o = en_i && (cnt_q >= skew_q) && (cnt_q < skew_q + HIGH);
endmodule // pldld_div_model

/* bench/test_pldld_top.sv */
// self-checking bench of the lock detector top
// assumes divider models on both loops and a 100 MHz clock
`timescale 1ns/1ns
module test_pldld_top;
  localparam int PD = 40;
  logic clk_i;
  logic reset_i;
  pldld_pkg::pldld_bus_req_t bus_i;
  logic [31:0] rd_data_o;
  logic ref1, fb1, ref2, fb2, en1, en2, hold_in;
  logic [7:0] skew1, skew2;
  logic holdover_o, lock1, lock2, irq_o;
  int fail_count = 0;
  int n_checks = 0;

  ////////////////////////////////////////////////////////////////////////
  pldld_top dut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i),
    .rd_data_o(rd_data_o), .first_ref_edge_i(ref1),
    .first_fb_edge_i(fb1), .second_ref_edge_i(ref2),
    .second_fb_edge_i(fb2), .holdover_enter_i(hold_in),
    .holdover_o(holdover_o), .first_loop_lock_o(lock1),
    .second_loop_lock_o(lock2), .irq_o(irq_o));
  pldld_div_model #(.PERIOD(PD)) div1 (.clk_i(clk_i), .en_i(en1),
    .skew_i(skew1), .ref_o(ref1), .fb_o(fb1));
  pldld_div_model #(.PERIOD(PD)) div2 (.clk_i(clk_i), .en_i(en2),
    .skew_i(skew2), .ref_o(ref2), .fb_o(fb2));

  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // returns just after an edge, where registered outputs have settled
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.wdata <= d;
    bus_i.wr <= 1'b1;
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1;
    check(rd_data_o, exp);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    wait_clk(6000);
    fail_count++;
    print_verdict();
  end

  initial begin
    int i;
    reset_i = 1'b1;
    bus_i = '0;
    en1 = 1'b0;
    en2 = 1'b0;
    skew1 = 8'h02;
    skew2 = 8'h07;
    hold_in = 1'b0;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    // reset values, read-only and unmapped places
    rd(pldld_pkg::OFS_WINDOW, 32'h0000_0404);
    for (i = 1; i < 4; i++) begin
      rd(8'(4 * i), 32'h0000_0400);
    end
    wr(pldld_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    wr(pldld_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
    wr(8'h1C, 32'hFFFF_FFFF);
    for (i = 4; i < 8; i++) begin
      rd(8'(4 * i), 32'h0000_0000);
    end
    $display("test registers done");

    // loop one: target 3, skew 2 inside window 4
    wr(pldld_pkg::OFS_TGT1, 32'h0000_0003);
    wr(pldld_pkg::OFS_IRQ_MASK, 32'h0000_0009);
    rd(pldld_pkg::OFS_TGT1, 32'h0000_0003);
    en1 <= 1'b1;
    wait_clk(2 * PD);
    check(lock1, 1'b0);
    wait_clk(PD);
    check(lock1, 1'b1);
    check(irq_o, 1'b1);
    rd(pldld_pkg::OFS_IRQ_STAT, 32'h0000_0001);
    rd(pldld_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    wait_clk(1);
    check(irq_o, 1'b0);
    $display("test first lock done");

    // window miss drops the lock, relock needs the whole count again
    skew1 <= 8'h0A;
    for (i = 0; i < 3 * PD && lock1 === 1'b1; i++) begin
      wait_clk(1);
    end
    check(lock1, 1'b0);
    skew1 <= 8'h02;
    wait_clk(2 * PD);
    check(lock1, 1'b0);
    wait_clk(2 * PD);
    check(lock1, 1'b1);
    check(irq_o, 1'b1);
    rd(pldld_pkg::OFS_IRQ_STAT, 32'h0000_0009);
    $display("test relock done");

    // loop two: own window 6 and target 4, skew 7 then 6
    wr(pldld_pkg::OFS_WINDOW, 32'h0000_0604);
    wr(pldld_pkg::OFS_TGT2, 32'h0000_0004);
    rd(pldld_pkg::OFS_WINDOW, 32'h0000_0604);
    en2 <= 1'b1;
    wait_clk(6 * PD);
    check(lock2, 1'b0);
    skew2 <= 8'h06;
    wait_clk(5 * PD);
    check(lock2, 1'b1);
    check(lock1, 1'b1);
    $display("test second lock done");

    // holdover exit on loop one window with its own target, masked out
    wr(pldld_pkg::OFS_HOLD_TGT, 32'h0000_0005);
    wr(pldld_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    rd(pldld_pkg::OFS_IRQ_STAT, 32'h0000_0002);
    @(posedge clk_i);
    hold_in <= 1'b1;
    @(posedge clk_i);
    hold_in <= 1'b0;
    wait_clk(1);
    check(holdover_o, 1'b1);
    rd(pldld_pkg::OFS_STATUS, 32'h0000_0007);
    wait_clk(3 * PD);
    check(holdover_o, 1'b1);
    wait_clk(3 * PD);
    check(holdover_o, 1'b0);
    check(irq_o, 1'b0);
    rd(pldld_pkg::OFS_IRQ_STAT, 32'h0000_0004);
    rd(pldld_pkg::OFS_STATUS, 32'h0000_0003);
    $display("test holdover done");
    print_verdict();
  end
endmodule // test_pldld_top

/* hdl/pldld_lock_cnt.sv */
// consecutive in-window counter producing one lock event
// assumes good and bad arrive as single-cycle pulses, never together
`timescale 1ns/1ns
module pldld_lock_cnt #(
  parameter int CNT_W = pldld_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control
  input wire logic clear_i,
  input wire logic good_i,
  input wire logic bad_i,
  input wire logic [CNT_W-1:0] target_i,
  // results
  output logic locked_o,
  output logic rise_o,
  output logic fall_o
);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W:0] next_cnt;

  assign next_cnt = {1'b0, count_q} + (CNT_W+1)'(1);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_q <= '0;
      locked_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (clear_i || bad_i) begin
        count_q <= '0;
        locked_o <= 1'b0;
        fall_o <= locked_o && bad_i;
      end else if (good_i && !locked_o) begin
        count_q <= next_cnt[CNT_W-1:0];
        if (next_cnt >= {1'b0, target_i}) begin
          locked_o <= 1'b1;
          rise_o <= 1'b1;
        end
      end
    end
  end

  a_lock_at_target: assert property (@(posedge clk_i)
    disable iff (reset_i)
    (good_i && !clear_i && !bad_i && next_cnt >= {1'b0, target_i})
    |=> locked_o)
    else $error("target reached without lock");

  a_no_early_lock: assert property (@(posedge clk_i)
    disable iff (reset_i)
    $rose(locked_o) |-> $past(next_cnt) >= {1'b0, $past(target_i)})
    else $error("lock raised before target count");

  a_bad_clears: assert property (@(posedge clk_i)
    disable iff (reset_i)
    bad_i |=> (count_q == '0) && !locked_o)
    else $error("window miss did not clear count and lock");

endmodule // pldld_lock_cnt

/* hdl/pldld_phase_win.sv */
// per-loop edge synchroniser and phase window judge
// assumes reference and feedback edges arrive asynchronously on pins
`timescale 1ns/1ns
module pldld_phase_win #(
  parameter int WIN_W = pldld_pkg::WIN_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // divider outputs
  input wire logic ref_i,
  input wire logic fb_i,
  // window in clock cycles
  input wire logic [WIN_W-1:0] window_i,
  // one result per phase detector cycle
  output logic good_o,
  output logic bad_o
);

  typedef enum {S_IDLE, S_WAIT_FB, S_WAIT_REF, S_LATE_FB, S_LATE_REF}
    pldld_pw_state_t;

  logic [2:0] ref_s_q;
  logic [2:0] fb_s_q;
  logic ref_f_q;
  logic fb_f_q;
  logic ref_rise;
  logic fb_rise;
  pldld_pw_state_t state_q;
  logic [WIN_W-1:0] elapsed_q;
  logic expired;

  ////////////////////////////////////////////////////////////////////////
  // three-stage sync, level accepted when stages two and three agree
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_s_q <= 3'h0;
      fb_s_q <= 3'h0;
    end else begin
      ref_s_q <= {ref_s_q[1:0], ref_i};
      fb_s_q <= {fb_s_q[1:0], fb_i};
    end
  end

  assign ref_rise = (ref_s_q[1] == ref_s_q[2]) && ref_s_q[2] && !ref_f_q;
  assign fb_rise = (fb_s_q[1] == fb_s_q[2]) && fb_s_q[2] && !fb_f_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ref_f_q <= 1'b0;
      fb_f_q <= 1'b0;
    end else begin
      if (ref_s_q[1] == ref_s_q[2]) ref_f_q <= ref_s_q[2];
      if (fb_s_q[1] == fb_s_q[2]) fb_f_q <= fb_s_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pairing: the first edge opens the window, the other must follow
  assign expired = (elapsed_q >= window_i);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= S_IDLE;
      elapsed_q <= '0;
      good_o <= 1'b0;
      bad_o <= 1'b0;
    end else begin
      good_o <= 1'b0;
      bad_o <= 1'b0;
      if (elapsed_q != '1) elapsed_q <= elapsed_q + WIN_W'(1);
      case (state_q)
        S_IDLE: begin
          elapsed_q <= '0;
          if (ref_rise && fb_rise) good_o <= 1'b1;
          else if (ref_rise) state_q <= S_WAIT_FB;
          else if (fb_rise) state_q <= S_WAIT_REF;
        end
        S_WAIT_FB: begin
          if (fb_rise) begin
            good_o <= !expired;
            bad_o <= expired;
            state_q <= S_IDLE;
          end else if (expired) begin
            bad_o <= 1'b1;
            state_q <= S_LATE_FB;
          end
        end
        S_WAIT_REF: begin
          if (ref_rise) begin
            good_o <= !expired;
            bad_o <= expired;
            state_q <= S_IDLE;
          end else if (expired) begin
            bad_o <= 1'b1;
            state_q <= S_LATE_REF;
          end
        end
        // late partner still owed; swallow it so pairs stay aligned
        S_LATE_FB: if (fb_rise) state_q <= S_IDLE;
        S_LATE_REF: if (ref_rise) state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  a_late_edge_bad: assert property (@(posedge clk_i)
    disable iff (reset_i)
    (state_q == S_WAIT_FB && expired && !fb_rise) |=> bad_o)
    else $error("missing feedback edge not judged out of window");

  a_one_verdict: assert property (@(posedge clk_i)
    disable iff (reset_i)
    !(good_o && bad_o))
    else $error("both verdicts in one cycle");

endmodule // pldld_phase_win

/* hdl/pldld_top.sv */
// top of the digital lock detector: register port, three lock events,
// holdover exit and interrupt logic
// assumes divider edges on pins, holdover entry from same-clock logic
//
// Function
// - three events: loop one, loop two, holdover exit
// - loop events have own window and target; holdover exit has own target, loop one window
// - event only after target consecutive good cycles
// - out-of-window edge clears that event's count
// - loop lock event drives lock output true
// - holdover exit event leaves holdover
`timescale 1ns/1ns
module pldld_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire pldld_pkg::pldld_bus_req_t bus_i,
  output logic [pldld_pkg::DATA_W-1:0] rd_data_o,
  // loop one divider outputs
  input wire logic first_ref_edge_i,
  input wire logic first_fb_edge_i,
  // loop two divider outputs
  input wire logic second_ref_edge_i,
  input wire logic second_fb_edge_i,
  // holdover control
  input wire logic holdover_enter_i,
  output logic holdover_o,
  // lock indications
  output logic first_loop_lock_o,
  output logic second_loop_lock_o,
  // interrupt
  output logic irq_o
);

  logic [pldld_pkg::WIN_W-1:0] first_loop_window_width_q;
  logic [pldld_pkg::WIN_W-1:0] second_loop_window_width_q;
  logic [pldld_pkg::CNT_W-1:0] first_loop_lock_target_q;
  logic [pldld_pkg::CNT_W-1:0] second_loop_lock_target_q;
  logic [pldld_pkg::CNT_W-1:0] holdover_exit_target_q;
  logic [pldld_pkg::IRQ_W-1:0] irq_stat_q;
  logic [pldld_pkg::IRQ_W-1:0] irq_stat_d;
  logic [pldld_pkg::IRQ_W-1:0] irq_mask_q;
  logic [pldld_pkg::IRQ_W-1:0] irq_evt;
  logic [pldld_pkg::DATA_W-1:0] rd_data_d;
  logic holdover_q;
  logic irq_q;
  logic good1;
  logic bad1;
  logic good2;
  logic bad2;
  logic lock1;
  logic lock1_rise;
  logic lock1_fall;
  logic lock2;
  logic lock2_rise;
  logic lock2_fall;
  logic hold_done;
  logic hold_exit;
  logic hold_clear;
  logic wr_hit_win;
  logic rd_irq;
  pldld_pkg::pldld_status_t status;

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  assign wr_hit_win = bus_i.wr && (bus_i.addr == pldld_pkg::OFS_WINDOW);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_loop_window_width_q <= pldld_pkg::WIN_RST;
      second_loop_window_width_q <= pldld_pkg::WIN_RST;
    end else if (wr_hit_win) begin
      first_loop_window_width_q <=
        bus_i.wdata[pldld_pkg::WIN1_LSB +: pldld_pkg::WIN_W];
      second_loop_window_width_q <=
        bus_i.wdata[pldld_pkg::WIN2_LSB +: pldld_pkg::WIN_W];
    end
  end

  // targets change take effect on the next good cycle; a lower target
  // can therefore lock at once, which software must expect
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      first_loop_lock_target_q <= pldld_pkg::TGT_RST;
      second_loop_lock_target_q <= pldld_pkg::TGT_RST;
      holdover_exit_target_q <= pldld_pkg::HOLD_TGT_RST;
    end else if (bus_i.wr) begin
      case (bus_i.addr)
        pldld_pkg::OFS_TGT1: begin
          first_loop_lock_target_q <= bus_i.wdata[pldld_pkg::CNT_W-1:0];
        end
        pldld_pkg::OFS_TGT2: begin
          second_loop_lock_target_q <= bus_i.wdata[pldld_pkg::CNT_W-1:0];
        end
        pldld_pkg::OFS_HOLD_TGT: begin
          holdover_exit_target_q <= bus_i.wdata[pldld_pkg::CNT_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask_q <= pldld_pkg::IRQ_RST;
    end else if (bus_i.wr && bus_i.addr == pldld_pkg::OFS_IRQ_MASK) begin
      irq_mask_q <= bus_i.wdata[pldld_pkg::IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase judges, one per loop
  pldld_phase_win #(
    .WIN_W(pldld_pkg::WIN_W)
  ) u_win1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ref_i(first_ref_edge_i),
    .fb_i(first_fb_edge_i),
    .window_i(first_loop_window_width_q),
    .good_o(good1),
    .bad_o(bad1)
  );

  pldld_phase_win #(
    .WIN_W(pldld_pkg::WIN_W)
  ) u_win2 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ref_i(second_ref_edge_i),
    .fb_i(second_fb_edge_i),
    .window_i(second_loop_window_width_q),
    .good_o(good2),
    .bad_o(bad2)
  );

  ////////////////////////////////////////////////////////////////////////
  // three independent counters; loop one window shared by two of them
  pldld_lock_cnt #(
    .CNT_W(pldld_pkg::CNT_W)
  ) u_lock1 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(1'b0),
    .good_i(good1),
    .bad_i(bad1),
    .target_i(first_loop_lock_target_q),
    .locked_o(lock1),
    .rise_o(lock1_rise),
    .fall_o(lock1_fall)
  );

  pldld_lock_cnt #(
    .CNT_W(pldld_pkg::CNT_W)
  ) u_lock2 (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(1'b0),
    .good_i(good2),
    .bad_i(bad2),
    .target_i(second_loop_lock_target_q),
    .locked_o(lock2),
    .rise_o(lock2_rise),
    .fall_o(lock2_fall)
  );

  // held clear outside holdover so every entry starts a fresh count
  assign hold_clear = !holdover_q;

  pldld_lock_cnt #(
    .CNT_W(pldld_pkg::CNT_W)
  ) u_hold (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clear_i(hold_clear),
    .good_i(good1),
    .bad_i(bad1),
    .target_i(holdover_exit_target_q),
    .locked_o(),
    .rise_o(hold_done),
    .fall_o()
  );

  ////////////////////////////////////////////////////////////////////////
  // holdover flag and lock outputs
  assign hold_exit = hold_done && holdover_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      holdover_q <= 1'b0;
    end else if (hold_exit) begin
      holdover_q <= 1'b0;
    end else if (holdover_enter_i) begin
      holdover_q <= 1'b1;
    end
  end

  assign holdover_o = holdover_q;
  assign first_loop_lock_o = lock1;
  assign second_loop_lock_o = lock2;

  ////////////////////////////////////////////////////////////////////////
  // sticky interrupt status, cleared by reading it; new events win
  always_comb begin
    irq_evt = '0;
    irq_evt[pldld_pkg::IRQ_LOCK1] = lock1_rise;
    irq_evt[pldld_pkg::IRQ_LOCK2] = lock2_rise;
    irq_evt[pldld_pkg::IRQ_HOLD_EXIT] = hold_exit;
    irq_evt[pldld_pkg::IRQ_LOCK_LOST] = lock1_fall || lock2_fall;
  end

  assign rd_irq = bus_i.rd && (bus_i.addr == pldld_pkg::OFS_IRQ_STAT);
  assign irq_stat_d = (rd_irq ? '0 : irq_stat_q) | irq_evt;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat_q <= pldld_pkg::IRQ_RST;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // registered from next status so the pin changes in the same cycle as status, glitch free
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // read path: data valid only in the cycle after the strobe
  assign status.lock1 = lock1;
  assign status.lock2 = lock2;
  assign status.holdover = holdover_q;

  always_comb begin
    rd_data_d = '0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        pldld_pkg::OFS_WINDOW: begin
          rd_data_d[pldld_pkg::WIN1_LSB +: pldld_pkg::WIN_W] =
            first_loop_window_width_q;
          rd_data_d[pldld_pkg::WIN2_LSB +: pldld_pkg::WIN_W] =
            second_loop_window_width_q;
        end
        pldld_pkg::OFS_TGT1: begin
          rd_data_d[pldld_pkg::CNT_W-1:0] = first_loop_lock_target_q;
        end
        pldld_pkg::OFS_TGT2: begin
          rd_data_d[pldld_pkg::CNT_W-1:0] = second_loop_lock_target_q;
        end
        pldld_pkg::OFS_HOLD_TGT: begin
          rd_data_d[pldld_pkg::CNT_W-1:0] = holdover_exit_target_q;
        end
        pldld_pkg::OFS_STATUS: begin
          rd_data_d[pldld_pkg::ST_LOCK1] = status.lock1;
          rd_data_d[pldld_pkg::ST_LOCK2] = status.lock2;
          rd_data_d[pldld_pkg::ST_HOLD] = status.holdover;
        end
        pldld_pkg::OFS_IRQ_STAT: begin
          rd_data_d[pldld_pkg::IRQ_W-1:0] = irq_stat_q;
        end
        pldld_pkg::OFS_IRQ_MASK: begin
          rd_data_d[pldld_pkg::IRQ_W-1:0] = irq_mask_q;
        end
        default: rd_data_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= rd_data_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_in_hold_done;
    holdover_q ##0 hold_done;
  endsequence

  a_hold_exit: assert property (@(posedge clk_i)
    disable iff (reset_i)
    s_in_hold_done |=> !holdover_o [*1])
    else $error("holdover not left on exit event");

  a_lock_out: assert property (@(posedge clk_i)
    disable iff (reset_i)
    lock1_rise |-> first_loop_lock_o)
    else $error("loop one lock event without lock output");

  a_lock_drop: assert property (@(posedge clk_i)
    disable iff (reset_i)
    bad2 |=> !second_loop_lock_o)
    else $error("loop two lock kept after window miss");

  a_irq_sticky: assert property (@(posedge clk_i)
    disable iff (reset_i)
    hold_exit |=> irq_stat_q[pldld_pkg::IRQ_HOLD_EXIT])
    else $error("holdover exit not recorded in status");

endmodule // pldld_top

/* pkg/pldld_pkg.sv */
// constants, register map and carriers of the digital lock detector
// assumes a single 100 MHz clock and a plain strobe register port
package pldld_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // widths of window (clock cycles) and lock targets (pd cycles)
  localparam int WIN_W = 8;
  localparam int CNT_W = 16;

  // clock
  localparam int CLK_PERIOD_NS = 10;

  // byte offsets
  localparam logic [ADDR_W-1:0] OFS_WINDOW = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TGT1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TGT2 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_HOLD_TGT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;

  // field positions in the window register
  localparam int WIN1_LSB = 0;
  localparam int WIN2_LSB = 8;

  // reset values
  localparam logic [WIN_W-1:0] WIN_RST = 8'h04;
  localparam logic [CNT_W-1:0] TGT_RST = 16'h0400;
  localparam logic [CNT_W-1:0] HOLD_TGT_RST = 16'h0400;

  // interrupt bits, same layout in status and mask
  localparam int IRQ_W = 4;
  localparam int IRQ_LOCK1 = 0;
  localparam int IRQ_LOCK2 = 1;
  localparam int IRQ_HOLD_EXIT = 2;
  localparam int IRQ_LOCK_LOST = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;

  // status register bits
  localparam int ST_LOCK1 = 0;
  localparam int ST_LOCK2 = 1;
  localparam int ST_HOLD = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pldld_bus_req_t;

  typedef struct packed {
    logic holdover;
    logic lock2;
    logic lock1;
  } pldld_status_t;

endpackage
